/* dv/pin_board.sv */
// board side of one port: outside drivers, pullups and the resolved pin level
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  output logic      [7:0] pin
);
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (oe[b] === 1'b1) begin
        pin[b] = out[b];
      end else if (ext_drv[b] === 1'b1) begin
        pin[b] = ext_val[b];
      end else if (pullup_en[b] === 1'b1) begin
        pin[b] = 1'b1;
      end else begin
        // floating line: flip so a stale level never reads back as a match
        pin[b] = ~out[b];
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gpio_ports_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire  [7:0]  p_out [4];
  wire  [7:0]  p_oe [4];
  wire  [7:0]  pu [4];
  wire  [7:0]  pin [4];
  logic [7:0]  ext_val [4];
  logic [7:0]  ext_drv [4];
  logic [1:0]  sci_out;
  logic [1:0]  sci_oe;
  logic [3:0]  spi_out;
  logic [3:0]  spi_oe;
  logic [7:0]  irq_opt;
  logic        full_io;
  logic        irq_n;
  wire         ext_irq;
  logic [31:0] rd;
  logic [7:0]  pv;
  int          n_errors;
  int          comparisons;

  assign p_out[3][7] = 1'b0;
  assign p_oe[3][7]  = 1'b0;
  assign pu[0]       = 8'h00;
  assign pu[2]       = 8'h00;
  assign pu[3]       = 8'h00;

  parallel_io_ports DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .first_port_pins_in(pin[0]), .first_port_pins_out(p_out[0]),
    .first_port_pins_oe(p_oe[0]), .second_port_pins_in(pin[1]), .second_port_pins_out(p_out[1]),
    .second_port_pins_oe(p_oe[1]), .second_port_pullup_en(pu[1]), .third_port_pins_in(pin[2]),
    .third_port_pins_out(p_out[2]), .third_port_pins_oe(p_oe[2]), .fourth_port_pins_in(pin[3][6:0]),
    .fourth_port_pins_out(p_out[3][6:0]), .fourth_port_pins_oe(p_oe[3][6:0]), .sci_pin_out(sci_out),
    .sci_pin_oe(sci_oe), .spi_pin_out(spi_out), .spi_pin_oe(spi_oe), .port_b_irq_option_nv(irq_opt),
    .full_io_mode(full_io), .irq_n(irq_n), .ext_irq(ext_irq)
  );

  for (genvar i = 0; i < 4; i++) begin : g_board
    pin_board board (.out(p_out[i]), .oe(p_oe[i]), .pullup_en(pu[i]), .ext_val(ext_val[i]),
                     .ext_drv(ext_drv[i]), .pin(pin[i]));
  end

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic results;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer: hold the address phase, then the data phase, until hready
  task automatic bus(input logic [15:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rv);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {14'h0000, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d, rd);
  endtask

  task automatic rchk(input string what, input logic [15:0] idx, input logic [31:0] exp, input logic [31:0] m);
    bus(idx, 1'b0, 32'h0, rd);
    chk(what, exp & m, rd & m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic do_reset(input logic mode);
    hresetn <= 1'b0;
    full_io <= mode;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    settle(5);
  endtask

  initial begin
    #100us;
    n_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    results();
  end

  initial begin
    n_errors = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sci_out = 2'h0;
    sci_oe = 2'h0;
    spi_out = 4'h0;
    spi_oe = 4'h0;
    irq_opt = 8'h81;
    full_io = 1'b1;
    irq_n = 1'b1;
    ext_val = '{8'h5a, 8'hc3, 8'h3c, 8'h55};
    ext_drv = '{8'hff, 8'h7f, 8'hff, 8'hff};
    do_reset(1'b1);
    for (int i = 0; i < 4; i++) begin
      rchk("direction after reset", IDX_PORT_A_DIR + 16'(i), 32'h0, 32'hff);
      chk("oe after reset", 32'h0, {24'h0, p_oe[i]});
      wr(IDX_PORT_A_DATA + 16'(i), 32'h96);
      wr(IDX_PORT_A_DIR + 16'(i), 32'h0f);
      settle(3);
      chk("pin oe", 32'h0f, {24'h0, p_oe[i]});
      chk("pin out", 32'h06, {24'h0, p_out[i] & 8'h0f});
      pv = (i == 3) ? {ext_val[3][6], 1'b0, ext_val[3][5:0]} : ext_val[i];
      rchk("data read", IDX_PORT_A_DATA + 16'(i), {24'h0, 8'h06 | (pv & 8'hf0)},
           (i == 3) ? {24'h0, PORT_D_MASK} : 32'hff);
    end
    chk("pullup with pin0 output", 32'h80, {24'h0, pu[1]});
    wr(IDX_PORT_B_DATA, 32'h97);
    wr(IDX_PORT_B_DIR, 32'h0e);
    settle(3);
    chk("pullup after turnaround", 32'h81, {24'h0, pu[1]});
    chk("bus response", 32'h0, {31'h0, hresp});
    rchk("unmapped", 16'h0040, 32'h0, 32'hffffffff);
    sci_oe <= 2'b11;
    sci_out <= 2'b01;
    spi_oe <= 4'b1010;
    spi_out <= 4'b1000;
    settle(3);
    chk("serial oe", 32'h2f, {24'h0, p_oe[3]});
    chk("serial out", 32'h21, {24'h0, p_out[3] & 8'h2b});
    sci_oe <= 2'b00;
    spi_oe <= 4'b0000;
    do_reset(1'b0);
    chk("oe after second reset", 32'h0, {24'h0, p_oe[0] | p_oe[3]});
    wr(IDX_PORT_A_DIR, 32'hff);
    wr(IDX_PORT_D_DIR, 32'hff);
    settle(3);
    chk("data kept over reset", 32'h96, {24'h0, p_out[0]});
    chk("legacy fourth oe", 32'h0, {24'h0, p_oe[3]});
    rchk("legacy fourth read", IDX_PORT_D_DATA, 32'h95, {24'h0, PORT_D_MASK});
    wr(IDX_OPTION, 32'h0);
    rchk("legacy option", IDX_OPTION, 32'h0, 32'hff);
    do_reset(1'b1);
    rchk("option reset", IDX_OPTION, 32'h02, 32'hff);
    rchk("irq option byte", IDX_PORT_B_IRQOPT, 32'h81, 32'hff);
    chk("pullup inputs", 32'h81, {24'h0, pu[1]});
    wr(IDX_IRQ_MASK, 32'h1ff);
    wr(IDX_IRQ_STATUS, 32'h1ff);
    ext_val[1][0] <= 1'b0;
    settle(6);
    rchk("status pin fall", IDX_IRQ_STATUS, 32'h001, 32'h1ff);
    chk("irq raised", 32'h1, {31'h0, ext_irq});
    wr(IDX_IRQ_STATUS, 32'h001);
    settle(4);
    rchk("status level", IDX_IRQ_STATUS, 32'h001, 32'h1ff);
    wr(IDX_OPTION, 32'h00);
    wr(IDX_OPTION, 32'h02);
    rchk("option once", IDX_OPTION, 32'h00, 32'hff);
    wr(IDX_IRQ_STATUS, 32'h001);
    settle(4);
    rchk("status edge only", IDX_IRQ_STATUS, 32'h000, 32'h1ff);
    wr(IDX_IRQ_MASK, 32'h000);
    ext_val[1][0] <= 1'b1;
    settle(4);
    ext_val[1][0] <= 1'b0;
    settle(6);
    rchk("status edge", IDX_IRQ_STATUS, 32'h001, 32'h1ff);
    chk("irq masked", 32'h0, {31'h0, ext_irq});
    wr(IDX_IRQ_MASK, 32'h001);
    settle(3);
    chk("irq unmasked", 32'h1, {31'h0, ext_irq});
    ext_val[1][1] <= 1'b0;
    settle(6);
    rchk("disabled pin", IDX_IRQ_STATUS, 32'h001, 32'h1ff);
    wr(IDX_IRQ_MASK, 32'h100);
    irq_n <= 1'b0;
    settle(6);
    rchk("dedicated pin", IDX_IRQ_STATUS, 32'h101, 32'h1ff);
    chk("irq dedicated", 32'h1, {31'h0, ext_irq});
    irq_n <= 1'b1;
    wr(IDX_IRQ_STATUS, 32'h1ff);
    settle(4);
    rchk("status cleared", IDX_IRQ_STATUS, 32'h000, 32'h1ff);
    chk("irq low", 32'h0, {31'h0, ext_irq});
    results();
  end
endmodule
`default_nettype wire

/* src/gpio_ports_pkg.sv */
// constants shared by the parallel port block: register indices, field positions, reset values
package gpio_ports_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_PORT_A_DATA   = 16'h0000;
  localparam logic [15:0] IDX_PORT_B_DATA   = 16'h0001;
  localparam logic [15:0] IDX_PORT_C_DATA   = 16'h0002;
  localparam logic [15:0] IDX_PORT_D_DATA   = 16'h0003;
  localparam logic [15:0] IDX_PORT_A_DIR    = 16'h0004;
  localparam logic [15:0] IDX_PORT_B_DIR    = 16'h0005;
  localparam logic [15:0] IDX_PORT_C_DIR    = 16'h0006;
  localparam logic [15:0] IDX_PORT_D_DIR    = 16'h0007;
  localparam logic [15:0] IDX_OPTION        = 16'h0008;
  localparam logic [15:0] IDX_IRQ_STATUS    = 16'h0009;
  localparam logic [15:0] IDX_IRQ_MASK      = 16'h000a;
  localparam logic [15:0] IDX_PORT_B_IRQOPT = 16'h3ff0;

  localparam int          PORT_W       = 8;
  localparam int          PORT_D_PINS  = 7;
  // fourth port register bit 6 has no pin
  localparam logic [7:0]  PORT_D_MASK  = 8'hbf;

  // option register fields
  localparam int          OPT_RAM1_BIT      = 7;
  localparam int          OPT_RAM0_BIT      = 6;
  localparam int          OPT_IRQ_LEVEL_BIT = 1;
  localparam logic        OPT_IRQ_LEVEL_RST = 1'b1;
  localparam logic        OPT_RAM_RST       = 1'b0;

  // interrupt status: bits 7..0 second port pins, bit 8 dedicated pin
  localparam int          IRQ_SRC_W   = 9;
  localparam int          IRQ_PIN_BIT = 8;

  // fourth port pin positions of the serial functions
  localparam int          SCI_LSB = 0;
  localparam int          SCI_W   = 2;
  localparam int          SPI_LSB = 2;
  localparam int          SPI_W   = 4;

  // cycles after reset release before the mode strap is taken
  localparam logic [1:0]  STRAP_WAIT = 2'h2;

endpackage

/* src/parallel_io_ports.sv */
// four parallel ports with direction control, second-port pin interrupts, AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports
  import gpio_ports_pkg::*;
(
  input  wire  logic                   hclk,
  input  wire  logic                   hresetn,
  input  wire  logic                   hsel,
  input  wire  logic [31:0]            haddr,
  input  wire  logic [1:0]             htrans,
  input  wire  logic                   hwrite,
  input  wire  logic [2:0]             hsize,
  input  wire  logic [31:0]            hwdata,
  input  wire  logic                   hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire  logic [PORT_W-1:0]      first_port_pins_in,
  output logic [PORT_W-1:0]            first_port_pins_out,
  output logic [PORT_W-1:0]            first_port_pins_oe,
  input  wire  logic [PORT_W-1:0]      second_port_pins_in,
  output logic [PORT_W-1:0]            second_port_pins_out,
  output logic [PORT_W-1:0]            second_port_pins_oe,
  output logic [PORT_W-1:0]            second_port_pullup_en,
  input  wire  logic [PORT_W-1:0]      third_port_pins_in,
  output logic [PORT_W-1:0]            third_port_pins_out,
  output logic [PORT_W-1:0]            third_port_pins_oe,
  input  wire  logic [PORT_D_PINS-1:0] fourth_port_pins_in,
  output logic [PORT_D_PINS-1:0]       fourth_port_pins_out,
  output logic [PORT_D_PINS-1:0]       fourth_port_pins_oe,
  input  wire  logic [SCI_W-1:0]       sci_pin_out,
  input  wire  logic [SCI_W-1:0]       sci_pin_oe,
  input  wire  logic [SPI_W-1:0]       spi_pin_out,
  input  wire  logic [SPI_W-1:0]       spi_pin_oe,
  input  wire  logic [PORT_W-1:0]      port_b_irq_option_nv,
  input  wire  logic                   full_io_mode,
  input  wire  logic                   irq_n,
  output logic                         ext_irq
);

  // ---------------- pin synchronisers ----------------
  logic [PORT_W-1:0]      a_sync;
  logic [PORT_W-1:0]      b_sync;
  logic [PORT_W-1:0]      b_fall;
  logic [PORT_W-1:0]      c_sync;
  logic [PORT_D_PINS-1:0] d_sync;
  logic [PORT_W-1:0]      bopt_sync;
  logic                   irq_sync;
  logic                   irq_fall;
  logic                   mode_sync;

  pin_sync #(.W(PORT_W)) u_sync_a (.clk(hclk), .rst_n(hresetn), .d(first_port_pins_in), .sync(a_sync), .fall());
  pin_sync #(.W(PORT_W)) u_sync_b (.clk(hclk), .rst_n(hresetn), .d(second_port_pins_in), .sync(b_sync), .fall(b_fall));
  pin_sync #(.W(PORT_W)) u_sync_c (.clk(hclk), .rst_n(hresetn), .d(third_port_pins_in), .sync(c_sync), .fall());
  pin_sync #(.W(PORT_D_PINS)) u_sync_d (.clk(hclk), .rst_n(hresetn), .d(fourth_port_pins_in), .sync(d_sync), .fall());
  pin_sync #(.W(PORT_W)) u_sync_o (.clk(hclk), .rst_n(hresetn), .d(port_b_irq_option_nv), .sync(bopt_sync), .fall());
  pin_sync #(.W(1)) u_sync_i (.clk(hclk), .rst_n(hresetn), .d(irq_n), .sync(irq_sync), .fall(irq_fall));
  pin_sync #(.W(1)) u_sync_m (.clk(hclk), .rst_n(hresetn), .d(full_io_mode), .sync(mode_sync), .fall());

  // ---------------- mode strap ----------------
  logic [1:0] strap_cnt_q;
  logic       full_io_q;

  // taken once after release; legacy (fourth port direction register ignored, option register off) until then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_cnt_q <= 2'h0;
      full_io_q   <= 1'b0;
    end else if (strap_cnt_q < STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end else if (strap_cnt_q == STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      full_io_q   <= mode_sync;
    end
  end

  // ---------------- AHB-Lite slave ----------------
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [29:0] idx_q;
  logic [31:0] rd_val;
  logic        take;
  logic        wr;

  assign take = hsel & htrans[1] & hready;
  assign wr   = wr_pend_q;

  // writes complete with no wait; reads take one wait state so data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 30'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hresp     <= 1'b0;
      if (rd_pend_q) begin
        hrdata    <= rd_val;
        hreadyout <= 1'b1;
      end else if (take) begin
        idx_q     <= haddr[31:2];
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  function automatic logic hit(input logic [29:0] i, input logic [15:0] r);
    hit = (i == {14'h0, r});
  endfunction

  // ---------------- port registers ----------------
  logic [PORT_W-1:0] data_a_q;
  logic [PORT_W-1:0] data_b_q;
  logic [PORT_W-1:0] data_c_q;
  logic [PORT_W-1:0] data_d_q;
  logic [PORT_W-1:0] dir_a_q;
  logic [PORT_W-1:0] dir_b_q;
  logic [PORT_W-1:0] dir_c_q;
  logic [PORT_W-1:0] dir_d_q;

  // data latches have no reset: their contents survive it
  always_ff @(posedge hclk) begin
    if (wr && hit(idx_q, IDX_PORT_A_DATA)) data_a_q <= hwdata[7:0];
    if (wr && hit(idx_q, IDX_PORT_B_DATA)) data_b_q <= hwdata[7:0];
    if (wr && hit(idx_q, IDX_PORT_C_DATA)) data_c_q <= hwdata[7:0];
    if (wr && hit(idx_q, IDX_PORT_D_DATA)) data_d_q <= hwdata[7:0] & PORT_D_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_a_q <= 8'h00;
      dir_b_q <= 8'h00;
      dir_c_q <= 8'h00;
      dir_d_q <= 8'h00;
    end else if (wr) begin
      if (hit(idx_q, IDX_PORT_A_DIR)) dir_a_q <= hwdata[7:0];
      if (hit(idx_q, IDX_PORT_B_DIR)) dir_b_q <= hwdata[7:0];
      if (hit(idx_q, IDX_PORT_C_DIR)) dir_c_q <= hwdata[7:0];
      if (hit(idx_q, IDX_PORT_D_DIR)) dir_d_q <= hwdata[7:0] & PORT_D_MASK;
    end
  end

  // ---------------- option register ----------------
  logic opt_ram0_q;
  logic opt_ram1_q;
  logic irq_level_q;
  logic opt_written_q;
  logic opt_wr;

  assign opt_wr = wr & hit(idx_q, IDX_OPTION) & full_io_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_ram0_q    <= OPT_RAM_RST;
      opt_ram1_q    <= OPT_RAM_RST;
      irq_level_q   <= OPT_IRQ_LEVEL_RST;
      opt_written_q <= 1'b0;
    end else if (opt_wr) begin
      opt_ram0_q    <= hwdata[OPT_RAM0_BIT];
      opt_ram1_q    <= hwdata[OPT_RAM1_BIT];
      opt_written_q <= 1'b1;
      if (!opt_written_q) irq_level_q <= hwdata[OPT_IRQ_LEVEL_BIT];
    end
  end

  // ---------------- fourth port mapping ----------------
  logic [PORT_D_PINS-1:0] d_dir_pins;
  logic [PORT_D_PINS-1:0] d_data_pins;
  logic [PORT_D_PINS-1:0] ser_oe;
  logic [PORT_D_PINS-1:0] ser_out;
  logic [PORT_W-1:0]      d_dir_eff;
  logic [PORT_W-1:0]      d_pin_reg;

  assign d_dir_eff   = full_io_q ? dir_d_q : 8'h00;
  assign d_dir_pins  = {d_dir_eff[7], d_dir_eff[5:0]};
  assign d_data_pins = {data_d_q[7], data_d_q[5:0]};
  assign d_pin_reg   = {d_sync[6], 1'b0, d_sync[5:0]};

  always_comb begin
    ser_oe  = '0;
    ser_out = '0;
    ser_oe[SCI_LSB +: SCI_W]  = sci_pin_oe;
    ser_out[SCI_LSB +: SCI_W] = sci_pin_out;
    ser_oe[SPI_LSB +: SPI_W]  = spi_pin_oe;
    ser_out[SPI_LSB +: SPI_W] = spi_pin_out;
  end

  // ---------------- pin drivers ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_port_pins_out   <= 8'h00;
      first_port_pins_oe    <= 8'h00;
      second_port_pins_out  <= 8'h00;
      second_port_pins_oe   <= 8'h00;
      second_port_pullup_en <= 8'h00;
      third_port_pins_out   <= 8'h00;
      third_port_pins_oe    <= 8'h00;
      fourth_port_pins_out  <= 7'h00;
      fourth_port_pins_oe   <= 7'h00;
    end else begin
      first_port_pins_oe    <= dir_a_q;
      first_port_pins_out   <= data_a_q & dir_a_q;
      second_port_pins_oe   <= dir_b_q;
      second_port_pins_out  <= data_b_q & dir_b_q;
      second_port_pullup_en <= bopt_sync & ~dir_b_q;
      third_port_pins_oe    <= dir_c_q;
      third_port_pins_out   <= data_c_q & dir_c_q;
      fourth_port_pins_oe   <= ser_oe | d_dir_pins;
      fourth_port_pins_out  <= (ser_oe & ser_out) | (~ser_oe & d_dir_pins & d_data_pins);
    end
  end

  // ---------------- external interrupt ----------------
  logic [IRQ_SRC_W-1:0] src_en;
  logic [IRQ_SRC_W-1:0] src_low;
  logic [IRQ_SRC_W-1:0] src_fall;
  logic [IRQ_SRC_W-1:0] ev;
  logic [IRQ_SRC_W-1:0] clr;
  logic [IRQ_SRC_W-1:0] status_q;
  logic [IRQ_SRC_W-1:0] mask_q;

  assign src_en   = {1'b1, bopt_sync};
  assign src_low  = {~irq_sync, ~b_sync};
  assign src_fall = {irq_fall, b_fall};
  // level mode keeps setting the flag while the pin stays low
  assign ev       = src_en & (src_fall | ({IRQ_SRC_W{irq_level_q}} & src_low));
  assign clr      = (wr && hit(idx_q, IDX_IRQ_STATUS)) ? hwdata[IRQ_SRC_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
      mask_q   <= '0;
      ext_irq  <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr) | ev; // set wins over clear
      if (wr && hit(idx_q, IDX_IRQ_MASK)) mask_q <= hwdata[IRQ_SRC_W-1:0];
      ext_irq  <= |(status_q & mask_q);
    end
  end

  // ---------------- read mux ----------------
  function automatic logic [7:0] mix(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] pin);
    mix = (dir & dat) | (~dir & pin);
  endfunction

  always_comb begin
    rd_val = 32'h0;
    if (hit(idx_q, IDX_PORT_A_DATA)) rd_val[7:0] = mix(dir_a_q, data_a_q, a_sync);
    if (hit(idx_q, IDX_PORT_B_DATA)) rd_val[7:0] = mix(dir_b_q, data_b_q, b_sync);
    if (hit(idx_q, IDX_PORT_C_DATA)) rd_val[7:0] = mix(dir_c_q, data_c_q, c_sync);
    if (hit(idx_q, IDX_PORT_D_DATA)) rd_val[7:0] = mix(d_dir_eff, data_d_q, d_pin_reg) & PORT_D_MASK;
    if (hit(idx_q, IDX_PORT_A_DIR)) rd_val[7:0] = dir_a_q;
    if (hit(idx_q, IDX_PORT_B_DIR)) rd_val[7:0] = dir_b_q;
    if (hit(idx_q, IDX_PORT_C_DIR)) rd_val[7:0] = dir_c_q;
    if (hit(idx_q, IDX_PORT_D_DIR)) rd_val[7:0] = dir_d_q;
    if (hit(idx_q, IDX_OPTION) && full_io_q) begin
      rd_val[OPT_RAM0_BIT]      = opt_ram0_q;
      rd_val[OPT_RAM1_BIT]      = opt_ram1_q;
      rd_val[OPT_IRQ_LEVEL_BIT] = irq_level_q;
    end
    if (hit(idx_q, IDX_IRQ_STATUS)) rd_val[IRQ_SRC_W-1:0] = status_q;
    if (hit(idx_q, IDX_IRQ_MASK)) rd_val[IRQ_SRC_W-1:0] = mask_q;
    if (hit(idx_q, IDX_PORT_B_IRQOPT)) rd_val[7:0] = bopt_sync;
  end

  // ---------------- assertions ----------------
  logic first_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) first_q <= 1'b1;
    else first_q <= 1'b0;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_dir_reset;
    first_q |-> (dir_a_q == 8'h00) && (dir_b_q == 8'h00) && (dir_c_q == 8'h00) && (dir_d_q == 8'h00)
                && (first_port_pins_oe == 8'h00) && (fourth_port_pins_oe == 7'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset");

  property p_oe_follows_dir;
    !first_q |=> first_port_pins_oe == $past(dir_a_q) && third_port_pins_oe == $past(dir_c_q);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("output enable not from direction");

  property p_dir_b_write;
    (wr && hit(idx_q, IDX_PORT_B_DIR)) |=> ##1 second_port_pins_oe == $past(hwdata[7:0], 2);
  endproperty
  a_dir_b_write: assert property (p_dir_b_write) else $error("second port direction write lost");

  property p_read_mix;
    (rd_pend_q && hit(idx_q, IDX_PORT_A_DATA)) |=>
      hreadyout && hrdata[7:0] == (($past(dir_a_q) & $past(data_a_q)) | (~$past(dir_a_q) & $past(a_sync)));
  endproperty
  a_read_mix: assert property (p_read_mix) else $error("port read value wrong");

  property p_pullup;
    !first_q |=> second_port_pullup_en == ($past(bopt_sync) & ~$past(dir_b_q));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup enable wrong");

  property p_b_edge;
    (b_fall[0] && bopt_sync[0]) |=> status_q[0];
  endproperty
  a_b_edge: assert property (p_b_edge) else $error("enabled pin edge not flagged");

  property p_level_mode;
    (irq_level_q && src_en[0] && src_low[0]) ##1 (irq_level_q && src_en[0] && src_low[0]) |-> status_q[0] ##1 status_q[0];
  endproperty
  a_level_mode: assert property (p_level_mode) else $error("level mode flag not held");

  property p_edge_only;
    (!irq_level_q && !b_fall[0] && !status_q[0] && !clr[0]) |=> !status_q[0];
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("edge mode flag without edge");

  property p_write_once;
    (opt_wr && opt_written_q) |=> $stable(irq_level_q);
  endproperty
  a_write_once: assert property (p_write_once) else $error("sensitivity changed after first write");

  property p_opt_legacy;
    (!full_io_q && rd_pend_q && hit(idx_q, IDX_OPTION)) |=> hrdata == 32'h0;
  endproperty
  a_opt_legacy: assert property (p_opt_legacy) else $error("option readable in legacy mode");

  property p_legacy_input;
    !full_io_q |=> fourth_port_pins_oe == $past(ser_oe);
  endproperty
  a_legacy_input: assert property (p_legacy_input) else $error("fourth port driven in legacy mode");

  property p_irq_out;
    (status_q[IRQ_PIN_BIT] && mask_q[IRQ_PIN_BIT]) |=> ext_irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt request missing");

  c_level_irq: cover property (irq_level_q && ext_irq && !irq_sync);
  c_second_write: cover property (opt_wr && opt_written_q);
  c_serial_drive: cover property (full_io_q && ser_oe[SCI_LSB] && !d_dir_pins[SCI_LSB]);

endmodule
`default_nettype wire

/* src/pin_sync.sv */
// two-flop synchroniser with falling-edge detect for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input  wire  logic         clk,
  input  wire  logic         rst_n,
  input  wire  logic [W-1:0] d,
  output logic       [W-1:0] sync,
  output logic       [W-1:0] fall
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // reset high: an idle pulled-up pin gives no edge at release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign sync = s2_q;
  assign fall = s3_q & ~s2_q;

endmodule
`default_nettype wire
